// File: hdl/fsps_pkg.sv
// fsps package: timing, register map, command codes and carrier structs
package fsps_pkg;
    localparam real CLK_PERIOD_NS = 40.0;
    localparam real TICK_NS = 1000.0;
    localparam int TICK_CYCLES = int'(TICK_NS / CLK_PERIOD_NS);
    localparam real PROG_MIN_MS = 3.7;
    localparam real PROG_MAX_MS = 4.5;
    localparam int PROG_MIN_TICKS = int'($ceil(PROG_MIN_MS * 1.0e6 / TICK_NS));
    localparam int PROG_MAX_TICKS = int'($floor(PROG_MAX_MS * 1.0e6 / TICK_NS));
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    localparam logic [2:0] LPM_WINDOW = 3'h3;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic IE_RST = 1'b0;
    localparam int CB_STORE = 0;
    localparam int CB_LOCK = 3;
    localparam int CB_BUSY = 6;
    localparam int CB_IE = 7;
    localparam int ST_OP_BUSY = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_EE_BUSY = 2;
    localparam logic [4:0] CMD_BUF_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REENABLE = 5'h11;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
    localparam logic [15:0] Z_LOCK = 16'h0001;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam logic [6:0] NO_READ_WHILE_WRITE_REGION_FIRST_PAGE = 7'h70;
    localparam int PAGE_LSB = 7;
    localparam int PAGE_MSB = 13;
    localparam int WORD_LSB = 1;
    localparam int WORD_MSB = 6;
    localparam int LOCK_LSB = 2;
    localparam int LOCK_MSB = 5;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_PROG} fsps_seq_t;
    typedef enum logic [1:0] {OP_ERASE, OP_WRITE, OP_LOCK} fsps_op_t;

    typedef struct packed {
        logic spm;
        logic lpm;
        logic [15:0] z;
        logic [7:0] r1;
        logic [7:0] r0;
    } fsps_core_req_t;

    typedef struct packed {
        logic start;
        fsps_op_t op;
        logic [6:0] page;
        logic [3:0] lock_prog;
        logic buf_wr;
        logic [5:0] buf_word;
        logic [15:0] buf_data;
        logic buf_clr;
    } fsps_flash_cmd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fsps_lpm_rsp_t;
endpackage

// File: hdl/fsps_op_timer.sv
// fsps flash operation timer: programming time, halt and region busy
module fsps_op_timer #(
    parameter int PROG_TIME_US = fsps_pkg::PROG_MIN_TICKS,
    parameter int TICK_CYCLES = fsps_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_por,
    input wire logic i_start,
    input wire logic i_blocks_rww,
    input wire logic i_no_read_while_write_region,
    input wire logic i_reenable,
    output logic o_busy,
    output logic o_done,
    output logic o_halt,
    output logic o_region_busy
);
    typedef struct packed {
        logic busy;
        logic done;
        logic halt;
        logic region_busy;
        logic [4:0] div;
        logic [12:0] us;
    } fsps_tmr_t;

    if (PROG_TIME_US < 1 || PROG_TIME_US > 8191 || TICK_CYCLES < 1 || TICK_CYCLES > 32) begin : g_chk
        $error("fsps_op_timer: unsupported timing parameters");
    end

    localparam logic [4:0] DIV_LAST = 5'(TICK_CYCLES - 1);
    localparam logic [12:0] US_LAST = 13'(PROG_TIME_US - 1);

    fsps_tmr_t r;
    fsps_tmr_t r_nxt;
    logic [17:0] busy_cyc_r;

    always_comb begin
        r_nxt = r;
        r_nxt.done = 1'b0;
        if (r.busy) begin
            if (r.div == DIV_LAST) begin
                r_nxt.div = 5'h00;
                if (r.us == US_LAST) begin
                    r_nxt.busy = 1'b0;
                    r_nxt.done = 1'b1;
                    r_nxt.halt = 1'b0;
                end else begin
                    r_nxt.us = r.us + 13'h0001;
                end
            end else begin
                r_nxt.div = r.div + 5'h01;
            end
        end else if (i_start) begin
            r_nxt.busy = 1'b1;
            r_nxt.div = 5'h00;
            r_nxt.us = 13'h0000;
            r_nxt.halt = i_no_read_while_write_region && i_blocks_rww;
            r_nxt.region_busy = r.region_busy || i_blocks_rww;
        end
        if (!r.busy && i_reenable) begin
            r_nxt.region_busy = 1'b0;
        end
    end

    // only power-on reset stops an operation
    always_ff @(posedge i_clk or posedge i_por) begin
        if (i_por) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_por) begin
        if (i_por) begin
            busy_cyc_r <= 18'h00000;
        end else begin
            busy_cyc_r <= r.busy ? busy_cyc_r + 18'h00001 : 18'h00000;
        end
    end

    assign o_busy = r.busy;
    assign o_done = r.done;
    assign o_halt = r.halt;
    assign o_region_busy = r.region_busy;

    AST_PROG_TIME: assert property (@(posedge i_clk) disable iff (i_por)
        o_done |-> busy_cyc_r == 18'(TICK_CYCLES * PROG_TIME_US))
        else $error("operation time differs from programmed count");

    AST_HALT_IN_OP: assert property (@(posedge i_clk) disable iff (i_por)
        o_halt |-> o_busy ##1 (o_halt || o_done))
        else $error("halt outside an operation");
endmodule

// File: hdl/fsps_sequencer.sv
// fsps sequencer top: control register, store/load decoding, readback
//////////////////////////////////////////////////////////////////////////
// Summary of operation
// - pattern 0x05 plus store starts page write
// - rww page write keeps no_read_while_write_region readable
// - no_read_while_write_region page write halts the core
// - interrupt level while store enable clear
// - erase or write blocks rww reads
// - busy flag set while rww blocked
// - pattern 0x09 plus store sets locks
// - zero data bits 5:2 program locks
// - lock programming keeps whole flash readable
// - eeprom write refuses commands and readback
// - pointer 1 load returns lock byte
// - armed bits clear on timeout or use, for erase, write and lock only when the operation ends
// - pointer 0 load returns fuse low
// - pointer 3 load returns fuse high
// - programmed bits read zero, others one
// - reset never aborts running flash write
// - flash operations take 3.7 to 4.5 ms
// - store enable alone loads buffer word
// - pattern 0x03 plus store erases page
// - page in z13:7, word in z6:1
// - buffer cleared after write, re-enable, reset
//////////////////////////////////////////////////////////////////////////
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
module fsps_sequencer #(
    parameter int PROG_TIME_US = fsps_pkg::PROG_MIN_TICKS,
    parameter int TICK_CYCLES = fsps_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_por,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire fsps_pkg::fsps_core_req_t i_core,
    input wire logic i_eeprom_write_busy,
    input wire logic [7:0] i_lock_byte,
    input wire logic [7:0] i_fuse_low_byte,
    input wire logic [7:0] i_fuse_high_byte,
    output fsps_pkg::fsps_flash_cmd_t o_flash_cmd,
    output fsps_pkg::fsps_lpm_rsp_t o_lpm_rsp,
    output logic o_cpu_halt,
    output logic o_region_busy_flag,
    output logic o_irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic w_held;
        logic w_lane0;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic ie;
        logic [4:0] cmd;
        fsps_pkg::fsps_seq_t seq;
        logic [2:0] age;
        logic reen;
        fsps_pkg::fsps_flash_cmd_t fcmd;
        fsps_pkg::fsps_lpm_rsp_t lpm;
        logic irq;
    } fsps_st_t;

    // buffer clear stands during reset so the page buffer starts empty
    localparam fsps_st_t ST_RST = '{
        seq: fsps_pkg::SEQ_IDLE,
        ie: fsps_pkg::IE_RST,
        fcmd: '{op: fsps_pkg::OP_ERASE, buf_clr: 1'b1, default: '0},
        default: '0
    };

    fsps_st_t st_r;
    fsps_st_t st_nxt;
    logic t_busy;
    logic t_done;
    logic t_region_busy;
    logic store_enable_bit;
    logic spm_ok;
    logic lpm_ok;
    logic [7:0] ctrl_byte;
    logic [7:0] stat_byte;

    function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    function automatic logic legal_cmd(input logic [4:0] c);
        return c == fsps_pkg::CMD_BUF_LOAD || c == fsps_pkg::CMD_ERASE || c == fsps_pkg::CMD_WRITE
            || c == fsps_pkg::CMD_LOCK || c == fsps_pkg::CMD_REENABLE;
    endfunction

    //////////////////////////////////////////////////////////////////////
    assign store_enable_bit = (st_r.seq != fsps_pkg::SEQ_IDLE) || t_busy;
    assign spm_ok = i_core.spm && !i_eeprom_write_busy && st_r.seq == fsps_pkg::SEQ_ARMED;
    assign lpm_ok = i_core.lpm && !i_eeprom_write_busy && st_r.seq == fsps_pkg::SEQ_ARMED
        && st_r.cmd == fsps_pkg::CMD_LOCK && st_r.age < fsps_pkg::LPM_WINDOW;

    always_comb begin
        ctrl_byte = 8'h00;
        ctrl_byte[fsps_pkg::CB_STORE] = store_enable_bit;
        ctrl_byte[fsps_pkg::CB_LOCK:fsps_pkg::CB_STORE + 1] =
            (st_r.seq == fsps_pkg::SEQ_IDLE) ? 3'h0 : st_r.cmd[3:1];
        ctrl_byte[fsps_pkg::CB_BUSY] = t_region_busy;
        ctrl_byte[fsps_pkg::CB_IE] = st_r.ie;
        if (st_r.seq != fsps_pkg::SEQ_IDLE) begin
            ctrl_byte[fsps_pkg::CB_LOCK + 1] = st_r.cmd[4];
        end
        stat_byte = 8'h00;
        stat_byte[fsps_pkg::ST_OP_BUSY] = t_busy;
        stat_byte[fsps_pkg::ST_ARMED] = st_r.seq == fsps_pkg::SEQ_ARMED;
        stat_byte[fsps_pkg::ST_EE_BUSY] = i_eeprom_write_busy;
    end

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        st_nxt.fcmd.start = 1'b0;
        st_nxt.fcmd.buf_wr = 1'b0;
        st_nxt.fcmd.buf_clr = 1'b0;
        st_nxt.lpm.valid = 1'b0;
        st_nxt.reen = 1'b0;
        st_nxt.irq = st_r.ie && !store_enable_bit;

        unique case (st_r.seq)
            fsps_pkg::SEQ_IDLE: begin
            end
            fsps_pkg::SEQ_ARMED: begin
                st_nxt.age = st_r.age + 3'h1;
                if (spm_ok) begin
                    st_nxt.seq = fsps_pkg::SEQ_IDLE;
                    unique case (st_r.cmd)
                        fsps_pkg::CMD_BUF_LOAD: begin
                            st_nxt.fcmd.buf_wr = 1'b1;
                            st_nxt.fcmd.buf_word = i_core.z[fsps_pkg::WORD_MSB:fsps_pkg::WORD_LSB];
                            st_nxt.fcmd.buf_data = {i_core.r1, i_core.r0};
                        end
                        fsps_pkg::CMD_ERASE, fsps_pkg::CMD_WRITE: begin
                            st_nxt.seq = fsps_pkg::SEQ_PROG;
                            st_nxt.fcmd.start = 1'b1;
                            st_nxt.fcmd.op = (st_r.cmd == fsps_pkg::CMD_WRITE)
                                ? fsps_pkg::OP_WRITE : fsps_pkg::OP_ERASE;
                            st_nxt.fcmd.page = i_core.z[fsps_pkg::PAGE_MSB:fsps_pkg::PAGE_LSB];
                        end
                        fsps_pkg::CMD_LOCK: begin
                            st_nxt.seq = fsps_pkg::SEQ_PROG;
                            st_nxt.fcmd.start = 1'b1;
                            st_nxt.fcmd.op = fsps_pkg::OP_LOCK;
                            st_nxt.fcmd.lock_prog = ~i_core.r0[fsps_pkg::LOCK_MSB:fsps_pkg::LOCK_LSB];
                        end
                        default: begin
                            st_nxt.reen = 1'b1;
                            st_nxt.fcmd.buf_clr = 1'b1;
                        end
                    endcase
                end else if (lpm_ok) begin
                    st_nxt.seq = fsps_pkg::SEQ_IDLE;
                    st_nxt.lpm.valid = 1'b1;
                    unique case (i_core.z)
                        fsps_pkg::Z_FUSE_LOW: st_nxt.lpm.data = i_fuse_low_byte;
                        fsps_pkg::Z_LOCK: st_nxt.lpm.data = i_lock_byte;
                        fsps_pkg::Z_FUSE_HIGH: st_nxt.lpm.data = i_fuse_high_byte;
                        // other pointers leave the normal load path in charge
                        default: st_nxt.lpm.valid = 1'b0;
                    endcase
                end else if (st_r.age == fsps_pkg::SPM_WINDOW - 3'h1) begin
                    st_nxt.seq = fsps_pkg::SEQ_IDLE;
                end
            end
            fsps_pkg::SEQ_PROG: begin
                if (t_done) begin
                    st_nxt.seq = fsps_pkg::SEQ_IDLE;
                    st_nxt.fcmd.buf_clr = st_r.fcmd.op == fsps_pkg::OP_WRITE;
                end
            end
            default: st_nxt.seq = fsps_pkg::SEQ_IDLE;
        endcase

        // write address and data are taken independently
        if (st_r.awready && i_awvalid) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr = i_awaddr;
        end
        if (st_r.wready && i_wvalid) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = i_wdata[7:0];
            st_nxt.w_lane0 = i_wstrb[0];
        end
        if (st_r.bvalid && i_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = fsps_pkg::RESP_OKAY;
            if (hits(st_r.awaddr, fsps_pkg::CTRL_OFS)) begin
                if (st_r.w_lane0) begin
                    st_nxt.ie = st_r.wdata[fsps_pkg::CB_IE];
                    if (st_nxt.seq != fsps_pkg::SEQ_PROG && !t_busy && !i_eeprom_write_busy
                        && legal_cmd(st_r.wdata[4:0])) begin
                        st_nxt.seq = fsps_pkg::SEQ_ARMED;
                        st_nxt.cmd = st_r.wdata[4:0];
                        st_nxt.age = 3'h0;
                    end
                end
            end else if (!hits(st_r.awaddr, fsps_pkg::STAT_OFS)) begin
                st_nxt.bresp = fsps_pkg::RESP_SLVERR;
            end
        end

        if (st_r.rvalid && i_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (st_r.arready && i_arvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = fsps_pkg::RESP_OKAY;
            st_nxt.rdata = 32'h00000000;
            if (hits(i_araddr, fsps_pkg::CTRL_OFS)) begin
                st_nxt.rdata[7:0] = ctrl_byte;
            end else if (hits(i_araddr, fsps_pkg::STAT_OFS)) begin
                st_nxt.rdata[7:0] = stat_byte;
            end else begin
                st_nxt.rresp = fsps_pkg::RESP_SLVERR;
            end
        end
        st_nxt.awready = !st_nxt.aw_held;
        st_nxt.wready = !st_nxt.w_held;
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // only no_read_while_write_region targets halt
    // lock writes neither halt nor block
    fsps_op_timer #(
        .PROG_TIME_US(PROG_TIME_US),
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .i_clk(i_clk),
        .i_por(i_por),
        .i_start(st_r.fcmd.start),
        .i_blocks_rww(st_r.fcmd.op != fsps_pkg::OP_LOCK),
        .i_no_read_while_write_region(st_r.fcmd.page >= fsps_pkg::NO_READ_WHILE_WRITE_REGION_FIRST_PAGE),
        .i_reenable(st_r.reen),
        .o_busy(t_busy),
        .o_done(t_done),
        .o_halt(o_cpu_halt),
        .o_region_busy(t_region_busy)
    );

    assign o_awready = st_r.awready;
    assign o_wready = st_r.wready;
    assign o_bvalid = st_r.bvalid;
    assign o_bresp = st_r.bresp;
    assign o_arready = st_r.arready;
    assign o_rvalid = st_r.rvalid;
    assign o_rdata = st_r.rdata;
    assign o_rresp = st_r.rresp;
    assign o_flash_cmd = st_r.fcmd;
    assign o_lpm_rsp = st_r.lpm;
    assign o_region_busy_flag = t_region_busy;
    assign o_irq = st_r.irq;

    //////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset || i_por);

    AST_IRQ_LEVEL: assert property (
        (st_r.ie && !store_enable_bit) |=> o_irq)
        else $error("interrupt missing while store enable clear");
    AST_PAGE_WRITE: assert property (
        (spm_ok && st_r.cmd == fsps_pkg::CMD_WRITE) |=> o_flash_cmd.start
        && o_flash_cmd.op == fsps_pkg::OP_WRITE && o_flash_cmd.page == $past(i_core.z[13:7]))
        else $error("page write not started from pointer page");
    AST_WINDOW_END: assert property (
        (st_r.seq == fsps_pkg::SEQ_ARMED && st_r.age == 3'h3 && !spm_ok && !lpm_ok
        && !(st_r.aw_held && st_r.w_held && !st_r.bvalid))
        |=> st_r.seq == fsps_pkg::SEQ_IDLE ##1 !o_flash_cmd.start)
        else $error("arming outlived four cycles");
    AST_NO_READ_WHILE_WRITE_REGION_HALT: assert property (
        (o_flash_cmd.start && o_flash_cmd.op != fsps_pkg::OP_LOCK && o_flash_cmd.page >= 7'h70)
        |=> o_cpu_halt [*4])
        else $error("core not halted for no_read_while_write_region operation");
    AST_RWW_RUNS: assert property (
        (o_flash_cmd.start && o_flash_cmd.page < 7'h70) |=> !o_cpu_halt [*4])
        else $error("core halted for rww operation");
    AST_LOCK_RUNS: assert property (
        (o_flash_cmd.start && o_flash_cmd.op == fsps_pkg::OP_LOCK) |=> !o_cpu_halt && t_busy)
        else $error("lock write halted the core");
    AST_REGION_BUSY: assert property (
        (o_flash_cmd.start && o_flash_cmd.op != fsps_pkg::OP_LOCK) |=> o_region_busy_flag
        throughout (t_busy [*2]))
        else $error("region busy flag not set during operation");
    AST_EE_REFUSE: assert property (
        i_eeprom_write_busy |=> !o_flash_cmd.start && !o_flash_cmd.buf_wr && !o_lpm_rsp.valid)
        else $error("instruction accepted during eeprom write");
    AST_LOCK_READ: assert property (
        (lpm_ok && i_core.z == 16'h0001) |=> o_lpm_rsp.valid && o_lpm_rsp.data == $past(i_lock_byte))
        else $error("lock byte readback wrong");
    AST_FUSE_LOW: assert property (
        (lpm_ok && i_core.z == 16'h0000) |=> o_lpm_rsp.data == $past(i_fuse_low_byte))
        else $error("fuse low readback wrong");
    AST_FUSE_HIGH: assert property (
        (lpm_ok && i_core.z == 16'h0003) |=> o_lpm_rsp.data == $past(i_fuse_high_byte))
        else $error("fuse high readback wrong");
    AST_LOCK_MAP: assert property (
        (spm_ok && st_r.cmd == fsps_pkg::CMD_LOCK) |=> o_flash_cmd.lock_prog == ~$past(i_core.r0[5:2]))
        else $error("lock programming mask wrong");
    AST_BUF_CLEAR: assert property (
        (t_done && st_r.seq == fsps_pkg::SEQ_PROG && o_flash_cmd.op == fsps_pkg::OP_WRITE)
        |=> o_flash_cmd.buf_clr ##1 !o_flash_cmd.buf_clr)
        else $error("buffer not cleared after page write");
    AST_BUSY_IGNORE: assert property (
        t_busy |=> st_r.seq != fsps_pkg::SEQ_ARMED)
        else $error("command armed during operation");

    COV_PAGE_WRITE: cover property (o_flash_cmd.start && o_flash_cmd.op == fsps_pkg::OP_WRITE ##[1:200] t_done);
    COV_LOCK_READ: cover property (o_lpm_rsp.valid);
    COV_REENABLE: cover property (o_region_busy_flag ##1 !o_region_busy_flag);
endmodule

// File: verification/fsps_core_model.sv
// fsps core model: issues store and load program instructions
module fsps_core_model (
    input wire logic i_clk,
    output fsps_pkg::fsps_core_req_t o_core
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_core = '0;
    task automatic issue(input logic s, input logic l, input logic [15:0] z, input logic [7:0] r0);
        o_core <= {s, l, z, 8'hff, r0};
        @(posedge i_clk);
        // fields inverted once released, never left at last value
        o_core <= {2'b00, ~z, 8'h00, ~r0};
    endtask
endmodule

// File: verification/flash_self_program_sequencer_tb.sv
// fsps testbench: bus tasks, core model, result queue
module flash_self_program_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, por = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, eeb = 0;
    logic [7:0] awaddr = '0, araddr = '0, lockb = '0, fl = '0, fh = '0, r0v;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic [6:0] pg;
    logic awready, wready, bvalid, arready, rvalid, halt, rbusy, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    fsps_pkg::fsps_core_req_t core;
    fsps_pkg::fsps_flash_cmd_t cmd;
    fsps_pkg::fsps_lpm_rsp_t lrsp;
    logic [22:0] expq[$];
    int bad_count = 0, samples_checked = 0, cyc = 0;
    // short programming time: 4 ticks of 2 cycles
    fsps_sequencer #(.PROG_TIME_US(4), .TICK_CYCLES(2)) dut_u (.i_clk(clk), .i_reset(rst), .i_por(por),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
        .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .i_core(core), .i_eeprom_write_busy(eeb), .i_lock_byte(lockb),
        .i_fuse_low_byte(fl), .i_fuse_high_byte(fh), .o_flash_cmd(cmd), .o_lpm_rsp(lrsp),
        .o_cpu_halt(halt), .o_region_busy_flag(rbusy), .o_irq(irq));
    fsps_core_model core_u (.i_clk(clk), .o_core(core));
    initial forever #20 clk = ~clk;
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {awvalid, wvalid, bready, awaddr, wdata, wstrb} <= {3'b111, a, 24'h0, d, 4'h1};
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        chk("bresp", bresp, fsps_pkg::RESP_OKAY);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m, input logic [9:0] e);
        {arvalid, rready, araddr} <= {2'b11, a};
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        chk(n, {rresp, rdata[7:0] & m}, e);
    endtask
    //////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            final_report();
        end else if (lrsp.valid === 1'b1 || cmd.start === 1'b1 || cmd.buf_wr === 1'b1) begin
            if (expq.size() == 0) chk("unexpected result", 1, 0);
            else chk("core result", lrsp.valid ? 23'({6'h0, lrsp.data}) : cmd.buf_wr ? {1'b1, cmd.buf_word,
                cmd.buf_data} : 23'({1'b1, cmd.op, cmd.op == fsps_pkg::OP_LOCK ? 7'h0 : cmd.page,
                cmd.op == fsps_pkg::OP_LOCK ? cmd.lock_prog : 4'h0}),
                expq.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h5b31f7a4));
        repeat (5) @(posedge clk);
        {rst, por, lockb, fl, fh} <= {2'b00, 24'($urandom)};
        @(posedge clk);
        rc("ctrl", 8'h00, 8'hff, {fsps_pkg::RESP_OKAY, 8'h00});
        rc("unmapped", 8'h08, 8'h00, {fsps_pkg::RESP_SLVERR, 8'h00});
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            expq.push_back(23'({6'h0, i == 0 ? fl : (i == 1 ? lockb : fh)}));
            wr(8'h00, 8'h09);
            core_u.issue(1'b0, 1'b1, (i == 2) ? 16'h3 : 16'(i), 8'hff);
        end
        $display("test readback done");
        eeb <= 1;
        wr(8'h00, 8'h09);
        core_u.issue(1'b0, 1'b1, 16'h1, 8'hff);
        rc("status", 8'h04, 8'h07, {fsps_pkg::RESP_OKAY, 8'h04});
        eeb <= 0;
        wr(8'h00, 8'h09);
        repeat (4) @(posedge clk);
        core_u.issue(1'b0, 1'b1, 16'h1, 8'hff);
        rc("status", 8'h04, 8'h07, {fsps_pkg::RESP_OKAY, 8'h00});
        $display("test refusal done");
        r0v = {2'b11, 4'($urandom), 2'b11};
        expq.push_back(23'({1'b1, fsps_pkg::OP_LOCK, 7'h0, ~r0v[5:2]}));
        wr(8'h00, 8'h09);
        core_u.issue(1'b1, 1'b0, 16'h1, r0v);
        repeat (12) @(posedge clk);
        rc("ctrl", 8'h00, 8'h41, {fsps_pkg::RESP_OKAY, 8'h00});
        $display("test lock write done");
        for (int p = 0; p < 3; p++) begin
            pg = (p == 2) ? 7'h70 : 7'h10;
            expq.push_back(23'({1'b1, p ? fsps_pkg::OP_WRITE : fsps_pkg::OP_ERASE, pg, 4'h0}));
            wr(8'h00, p ? 8'h05 : 8'h03);
            core_u.issue(1'b1, 1'b0, {2'b00, pg, 7'h0}, 8'h00);
            repeat (2) @(posedge clk);
            chk("halt", halt, p == 2);
            chk("region busy", rbusy, 1);
            if (p == 2) begin
                rst <= 1'b1;
                @(posedge clk);
                rst <= 1'b0;
                @(posedge clk);
                chk("halt after reset", halt, 1);
            end
            repeat (12) @(posedge clk);
            rc("ctrl", 8'h00, 8'h41, {fsps_pkg::RESP_OKAY, 8'h40});
            wr(8'h00, 8'h11);
            core_u.issue(1'b1, 1'b0, 16'h0, 8'h00);
            @(posedge clk);
            chk("buffer clear", cmd.buf_clr, 1);
            @(posedge clk);
            chk("region busy", rbusy, 0);
        end
        $display("test page write done");
        wr(8'h00, 8'h80);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1);
        wr(8'h00, 8'h81);
        @(posedge clk);
        chk("irq", irq, 0);
        r0v = 8'($urandom);
        expq.push_back({1'b1, 6'h2a, 8'hff, r0v});
        core_u.issue(1'b1, 1'b0, 16'h0054, r0v);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1);
        $display("test interrupt done");
        chk("queue left", expq.size(), 0);
        final_report();
    end
endmodule
